// file: charger_status_pkg.sv
// Constants for the charger status word and its serial read port
package charger_status_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] CMD_CHARGER_INFORMATION_STATUS = 8'h3A;
  localparam logic [15:0] STATUS_UNMAPPED_VALUE         = 16'h0000;
  // ==========================================================
  // Field positions of the status word
  localparam int CFG_LSB       = 0;
  localparam int CFG_MSB       = 3;
  localparam int TRICKLE_BIT   = 4;
  localparam int PMODE_LSB     = 5;
  localparam int PMODE_MSB     = 6;
  localparam int MSTATE_LSB    = 7;
  localparam int MSTATE_MSB    = 9;
  localparam int LOW_RAIL_BIT  = 10;
  localparam int DISCHARGE_BIT = 11;
  localparam int INPUT_CUR_BIT = 12;
  localparam int LOOP_LSB      = 13;
  localparam int LOOP_MSB      = 14;
  localparam int REF_BIT       = 15;
  // ==========================================================
  // Default values and byte length
  localparam logic [3:0] CFG_UNREAD_VALUE = 4'h0;
  localparam logic [6:0] DEFAULT_ADDRESS  = 7'h09;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  // ==========================================================
  // Serial port states, Gray from each state to the next in the list
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h3,
    ST_CMD  = 4'h2,
    ST_CACK = 4'h6,
    ST_WDAT = 4'h7,
    ST_WACK = 4'h5,
    ST_RDAT = 4'h4,
    ST_RACK = 4'hC
  } port_state_t;
endpackage

// file: charger_status_register.sv
// Read-only charger status word behind a two-wire serial port
// What this block does
// (RL1) A 16-bit status word is readable by the host at command code 0x3A.
// (RL2) Bits 3:0 give one of sixteen strap configuration codes.
// (RL3) On battery alone the configuration field shows the strap only once it has been measured.
// (RL4) Bit 4 is 1 while trickle charging is active.
// (RL5) Bits 6:5 give the power stage mode: step-down, step-up, combined, reverse supply.
// (RL6) Bits 9:7 give the main state machine state.
// (RL7) Bit 10 is 1 when the low system rail throttle has tripped.
// (RL8) Bit 11 is 1 when the discharge current throttle has tripped.
// (RL9) Bit 12 is 1 when the input current throttle has tripped.
// (RL10) Bits 14:13 identify the active regulation loop.
// (RL11) Bit 15 is 1 while the internal reference is active, 0 in low power mode.
// (RL12) Host writes do not change the word, and a read shows current status.
`timescale 1ns/10ps
`default_nettype none
module charger_status_register
  import charger_status_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDRESS = DEFAULT_ADDRESS  // Arbitrary bus address
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output var  logic       SDA_OUT,
  output var  logic       SDA_OE,
  input  wire logic [3:0] CONFIG_STRAP_PIN,
  input  wire logic       STRAP_MEASURED,
  input  wire logic       TRICKLE_ACTIVE,
  input  wire logic [1:0] POWER_MODE,
  input  wire logic [2:0] MAIN_STATE,
  input  wire logic       LOW_RAIL_THROTTLE_FLAG,
  input  wire logic       DISCHARGE_THROTTLE_FLAG,
  input  wire logic       INPUT_CURRENT_THROTTLE_FLAG,
  input  wire logic [1:0] ACTIVE_LOOP,
  input  wire logic       REFERENCE_ACTIVE
);

  // ==========================================================
  // Input synchronisers
  logic [16:0] in_meta;
  logic [16:0] in_sync;
  logic [16:0] in_prev;
  logic [16:0] in_hold;
  logic [16:0] next_hold;
  logic [1:0]  pin_meta;
  logic [1:0]  pin_sync;
  logic        scl_prev;
  logic        sda_prev;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      in_meta  <= '0;
      in_sync  <= '0;
      in_prev  <= '0;
      in_hold  <= '0;
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      in_meta  <= {STRAP_MEASURED, REFERENCE_ACTIVE, ACTIVE_LOOP, INPUT_CURRENT_THROTTLE_FLAG,
                   DISCHARGE_THROTTLE_FLAG, LOW_RAIL_THROTTLE_FLAG, MAIN_STATE, POWER_MODE,
                   TRICKLE_ACTIVE, CONFIG_STRAP_PIN};
      in_sync  <= in_meta;
      in_prev  <= in_sync;
      in_hold  <= next_hold;
      pin_meta <= {SCL, SDA_IN};
      pin_sync <= pin_meta;
      scl_prev <= pin_sync[1];
      sda_prev <= pin_sync[0];
    end
  end

  // Keep a status sample only once two in a row agree, so no field shows a half-changed code
  assign next_hold = (in_sync == in_prev) ? in_sync : in_hold;

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_s      = pin_sync[1];
  assign sda_s      = pin_sync[0];
  assign scl_rise   = scl_s & ~scl_prev;
  assign scl_fall   = ~scl_s & scl_prev;
  assign start_seen = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_seen  = scl_s & scl_prev & ~sda_prev & sda_s;

  // ==========================================================
  // Live status word
  logic        strap_valid;
  logic [15:0] live_word;

  always_comb begin
    live_word = '0;
    live_word[CFG_MSB:CFG_LSB] = strap_valid ? in_hold[3:0] : CFG_UNREAD_VALUE;  // (RL2) (RL3)
    live_word[TRICKLE_BIT]             = in_hold[4];      // (RL4)
    live_word[PMODE_MSB:PMODE_LSB]     = in_hold[6:5];    // (RL5)
    live_word[MSTATE_MSB:MSTATE_LSB]   = in_hold[9:7];    // (RL6)
    live_word[LOW_RAIL_BIT]            = in_hold[10];     // (RL7)
    live_word[DISCHARGE_BIT]           = in_hold[11];     // (RL8)
    live_word[INPUT_CUR_BIT]           = in_hold[12];     // (RL9)
    live_word[LOOP_MSB:LOOP_LSB]       = in_hold[14:13];  // (RL10)
    live_word[REF_BIT]                 = in_hold[15];     // (RL11)
  end

  function automatic logic [15:0] read_word(input logic [7:0] code, input logic [15:0] word);
    if (code == CMD_CHARGER_INFORMATION_STATUS) begin
      read_word = word;  // (RL1)
    end else begin
      read_word = STATUS_UNMAPPED_VALUE;
    end
  endfunction

  // ==========================================================
  // Serial port state
  port_state_t state;
  port_state_t next_state;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [7:0]  sh;
  logic [7:0]  next_sh;
  logic [7:0]  cmd;
  logic [7:0]  next_cmd;
  logic [15:0] snap;
  logic [15:0] next_snap;
  logic        rw;
  logic        next_rw;
  logic        hi_byte;
  logic        next_hi_byte;
  logic        nack;
  logic        next_nack;
  logic        next_oe;
  logic        next_strap_valid;

  always_comb begin
    next_state       = state;
    next_cnt         = cnt;
    next_sh          = sh;
    next_cmd         = cmd;
    next_snap        = snap;
    next_rw          = rw;
    next_hi_byte     = hi_byte;
    next_nack        = nack;
    next_oe          = SDA_OE;
    next_strap_valid = strap_valid | in_sync[16];  // (RL3)
    if (stop_seen) begin
      next_state = ST_IDLE;
      next_oe    = 1'b0;
    end else if (start_seen) begin
      next_state = ST_ADDR;
      next_cnt   = '0;
      next_oe    = 1'b0;
    end else if (scl_rise) begin
      next_cnt = cnt + 4'h1;
      if (state == ST_ADDR || state == ST_CMD || state == ST_WDAT) begin
        next_sh = {sh[6:0], sda_s};
      end else if (state == ST_RACK) begin
        next_nack = sda_s;
      end
    end else if (scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (cnt == BITS_PER_BYTE) begin
            if (sh[7:1] == DEVICE_ADDRESS) begin
              next_state = ST_AACK;
              next_rw    = sh[0];
              next_oe    = 1'b1;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          next_cnt = '0;
          if (rw) begin
            next_snap    = read_word(cmd, live_word);  // (RL12)
            next_sh      = next_snap[7:0];
            next_hi_byte = 1'b0;
            next_oe      = ~next_snap[7];
            next_state   = ST_RDAT;
          end else begin
            next_oe    = 1'b0;
            next_state = ST_CMD;
          end
        end
        ST_CMD: begin
          if (cnt == BITS_PER_BYTE) begin
            next_cmd   = sh;
            next_oe    = 1'b1;
            next_state = ST_CACK;
          end
        end
        ST_CACK, ST_WACK: begin
          next_cnt   = '0;
          next_oe    = 1'b0;
          next_state = ST_WDAT;
        end
        ST_WDAT: begin
          if (cnt == BITS_PER_BYTE) begin
            next_oe    = 1'b1;  // (RL12)
            next_state = ST_WACK;
          end
        end
        ST_RDAT: begin
          if (cnt == BITS_PER_BYTE) begin
            next_oe    = 1'b0;
            next_state = ST_RACK;
          end else begin
            next_sh = {sh[6:0], 1'b0};
            next_oe = ~sh[6];
          end
        end
        ST_RACK: begin
          next_cnt = '0;
          if (nack || hi_byte) begin
            next_oe    = 1'b0;
            next_state = ST_IDLE;
          end else begin
            next_hi_byte = 1'b1;
            next_sh      = snap[15:8];
            next_oe      = ~snap[15];
            next_state   = ST_RDAT;
          end
        end
        default: begin
          next_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state       <= ST_IDLE;
      cnt         <= '0;
      sh          <= '0;
      cmd         <= '0;
      snap        <= '0;
      rw          <= 1'b0;
      hi_byte     <= 1'b0;
      nack        <= 1'b0;
      SDA_OE      <= 1'b0;
      SDA_OUT     <= 1'b0;
      strap_valid <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      sh          <= next_sh;
      cmd         <= next_cmd;
      snap        <= next_snap;
      rw          <= next_rw;
      hi_byte     <= next_hi_byte;
      nack        <= next_nack;
      SDA_OE      <= next_oe;
      SDA_OUT     <= 1'b0;
      strap_valid <= next_strap_valid;
    end
  end

endmodule
`default_nettype wire

// file: charger_status_register_assertions.sv
// Pin checks for the charger status port
`timescale 1ns/10ps
`default_nettype none
module charger_status_register_assertions (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE
);
  // ========
  // Data pin timing
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  chk_drive_low: assert property (!SDA_OUT)
    else $error("Drive value not zero");
  chk_reset_quiet: assert property ($fell(RST) |-> !SDA_OE ##1 !SDA_OE ##1 !SDA_OE)
    else $error("Drive after reset");
  chk_change_low: assert property ($changed(SDA_OE) |-> !SCL)
    else $error("Drive change with clock high");
  chk_ack_latency: assert property ($rose(SDA_OE) |-> !$past(SCL, 1) && !$past(SCL, 3))
    else $error("Drive too soon after clock fall");
  chk_fall_settle: assert property ($fell(SCL) |=> $stable(SDA_OE)[*2])
    else $error("Drive moved early");
  chk_bit_hold: assert property ($rose(SDA_OE) |-> SDA_OE[*8])
    else $error("Drive too short");
  chk_high_stable: assert property (SCL && $past(SCL, 4) |-> $stable(SDA_OE))
    else $error("Drive moved in high phase");
  chk_stop_quiet: assert property (SCL && $rose(SDA_IN) |=> !SDA_OE[*3])
    else $error("Drive after stop");
endmodule
bind charger_status_register charger_status_register_assertions u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .SCL(SCL), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE));
`default_nettype wire

// file: smbus_host_model.sv
// Two-wire bus host that reads and writes the status port
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  // ========
  // Bus phases of at least ten clocks
  localparam int HALF = 10;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    wait_n(3);
    sda_low <= 1'b0;
    wait_n(HALF);
    scl <= 1'b1;
    wait_n(HALF);
    sda_low <= 1'b1;
    wait_n(HALF);
    scl <= 1'b0;
  endtask
  task automatic stop();
    wait_n(3);
    sda_low <= 1'b1;
    wait_n(HALF);
    scl <= 1'b1;
    wait_n(HALF);
    sda_low <= 1'b0;
    wait_n(HALF);
  endtask
  task automatic put_bit(input logic b, output logic r);
    wait_n(3);
    sda_low <= ~b;
    wait_n(HALF);
    scl <= 1'b1;
    wait_n(HALF);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, r);
      d[i] = r;
    end
    put_bit(~ack, r);
  endtask
  task automatic read_word(input logic [6:0] a, input logic [7:0] c,
                           output logic [15:0] w, output logic ok);
    logic a0, a1, a2;
    start();
    send_byte({a, 1'b0}, a0);
    send_byte(c, a1);
    start();
    send_byte({a, 1'b1}, a2);
    get_byte(1'b1, w[7:0]);
    get_byte(1'b0, w[15:8]);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w);
    logic k;
    start();
    send_byte({a, 1'b0}, k);
    send_byte(c, k);
    send_byte(w[7:0], k);
    send_byte(w[15:8], k);
    stop();
  endtask
endmodule
`default_nettype wire

// file: charger_status_register_test.sv
// Self-checking bench for the charger status word
`timescale 1ns/10ps
`default_nettype none
module charger_status_register_test;
  import charger_status_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        meas = 1'b0;
  logic [15:0] stat = 16'h0000;
  logic [15:0] word;
  logic        ok;
  logic        scl;
  logic        host_low;
  logic        dev_oe;
  logic        sda;
  int          n_errors = 0;
  int          check_count = 0;
  // ========
  // Clock, wire and instances
  always #10 clk = ~clk;
  assign sda = ~(dev_oe | host_low);
  charger_status_register u_dut (
    .CLK_SYS(clk), .RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(dev_oe),
    .CONFIG_STRAP_PIN(stat[3:0]), .STRAP_MEASURED(meas), .TRICKLE_ACTIVE(stat[4]),
    .POWER_MODE(stat[6:5]), .MAIN_STATE(stat[9:7]), .LOW_RAIL_THROTTLE_FLAG(stat[10]),
    .DISCHARGE_THROTTLE_FLAG(stat[11]), .INPUT_CURRENT_THROTTLE_FLAG(stat[12]),
    .ACTIVE_LOOP(stat[14:13]), .REFERENCE_ACTIVE(stat[15]));
  smbus_host_model u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c);
    u_host.read_word(a, c, word, ok);
  endtask
  // ========
  // Tests
  initial begin
    #1_500_000;
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    stat <= 16'hFFFF;
    rd(DEFAULT_ADDRESS, CMD_CHARGER_INFORMATION_STATUS);
    check(word, 16'hFFF0);
    meas <= 1'b1;
    repeat (4) @(posedge clk);
    meas <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      stat <= {4{i[3:0]}};
      rd(DEFAULT_ADDRESS, CMD_CHARGER_INFORMATION_STATUS);
      check(word, {4{i[3:0]}});
      check({15'h0000, ok}, 16'h0001);
    end
    u_host.write_word(DEFAULT_ADDRESS, CMD_CHARGER_INFORMATION_STATUS, 16'h0000);
    rd(DEFAULT_ADDRESS, CMD_CHARGER_INFORMATION_STATUS);
    check(word, 16'hFFFF);
    rd(DEFAULT_ADDRESS, 8'h3B);
    check(word, STATUS_UNMAPPED_VALUE);
    rd(DEFAULT_ADDRESS ^ 7'h01, CMD_CHARGER_INFORMATION_STATUS);
    check(word, 16'hFFFF);
    check({15'h0000, ok}, 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
